// ### adc_power_reference_control.sv
// How it works
// R1: Control bit 0 selects the external reference and powers the reference amplifier down.
// R2: Result is straight binary; one code step equals the reference over 1024.
// R3: Power field 11 up, 00 down, 01 partial or 10 full down if trigger low.
// R4: Trigger level is judged exactly at the end of each conversion.
// R5: In automatic power-down modes a rising trigger edge starts power-up.
// R6: Partial power-down keeps the on-chip reference powered.
// R7: Device starts in low current; host must write 11 before converting.
// R8: Power-up takes one microsecond with external reference or from partial power-down.
// R9: Host waits about 182 microseconds after supply or long full power-down.
// R10: With partial power-down host may convert about 30 microseconds after supply.
// R11: Host keeps throughput at or below 250 kSPS with full power-down between conversions.
// R12: Host keeps the high trigger pulse no longer than the power-up time.
// R13: Transfers are full-duplex 16-bit words, MSB first, optionally two 8-bit halves.
// R14: With frame syncs tied to the trigger, host pulses it to arm the port.
// R15: Host discards the word read back during the first configuration transfer.
// R16: Host writes 6040 hex to power up, later 4040 hex for reads.
// R17: Host waits about one microsecond after power-up before the next trigger pulse.
// R18: Host reads the current result no earlier than 2.3 microseconds after trigger fall.
// R19: The 10-bit result is left-justified in the 16-bit word, MSB first.
// R20: Host idles the trigger high for high speed, low for automatic power-down.
// R21: Each falling trigger edge puts the sampler in hold and starts a conversion.
// R22: A trigger falling during power-up waits out power-up, then converts.
// R23: Power state machine updates once per conversion end from field and trigger.
package adc_pwr_pkg;

   // ----------------------------------------------------------------------
   // Timing.
   // ----------------------------------------------------------------------
   localparam int CLK_MHZ       = 100;
   localparam int CONV_TIME_NS  = 2300;
   localparam int PWRUP_TIME_NS = 1000;
   localparam int COLD_TIME_US  = 182;
   localparam int CONV_CYCLES   = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int PWRUP_CYCLES  = (PWRUP_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int COLD_CYCLES   = COLD_TIME_US * CLK_MHZ;

   // ----------------------------------------------------------------------
   // Serial word and control field layout.
   // ----------------------------------------------------------------------
   localparam int WORD_W     = 16;
   localparam int CODE_W     = 10;
   localparam int CTRL_LSB   = 6;
   localparam int EXTERNAL_REF_SELECT_BIT = 0;
   localparam int PD0_BIT    = 7;
   localparam int PD1_BIT    = 8;
   localparam int TIMER_W    = 16;

   localparam logic [1:0] PD_FULL_DOWN = 2'h0;
   localparam logic [1:0] PD_PARTIAL   = 2'h1;
   localparam logic [1:0] PD_AUTO_FULL = 2'h2;
   localparam logic [1:0] PD_FULL_UP   = 2'h3;

   typedef enum logic [2:0] {
      PWR_OFF,
      PWR_RISING,
      PWR_ACTIVE,
      PWR_PARTIAL,
      PWR_FULL
   } pwr_state_t;

endpackage

module adc_power_reference_control
   import adc_pwr_pkg::*;
#(
   parameter int COLD_START_CYCLES = COLD_CYCLES,
   parameter int WAKE_CYCLES       = PWRUP_CYCLES,
   parameter int CONVERT_CYCLES    = CONV_CYCLES
) (
   input  wire logic              ref_clk_i,
   input  wire logic              reset_i,
   input  wire logic              sclk_i,
   input  wire logic              receive_frame_sync_i,
   input  wire logic              transmit_frame_sync_i,
   input  wire logic              sdata_i,
   output logic                   sdata_o,
   input  wire logic              conv_trigger_n_i,
   input  wire logic [CODE_W-1:0] adc_code_i,
   output logic                   external_ref_select_o,
   output logic                   ref_amp_on_o,
   output logic                   core_power_on_o,
   output logic                   hold_o,
   output logic                   conv_done_o,
   output logic                   ready_o,
   output logic [1:0]             power_mode_o
);

   // ----------------------------------------------------------------------
   // Elaboration checks.
   // ----------------------------------------------------------------------
   if (COLD_START_CYCLES < 1 || COLD_START_CYCLES >= 2 ** TIMER_W ||
       WAKE_CYCLES < 1 || WAKE_CYCLES >= 2 ** TIMER_W ||
       CONVERT_CYCLES < 2 || CONVERT_CYCLES >= 2 ** TIMER_W) begin : g_bad_timing
      $error("Timing parameter outside the timer range.");
   end

   localparam logic [TIMER_W-1:0] COLD_LOAD = TIMER_W'(COLD_START_CYCLES - 1);
   localparam logic [TIMER_W-1:0] WAKE_LOAD = TIMER_W'(WAKE_CYCLES - 1);
   localparam logic [TIMER_W-1:0] CONV_LOAD = TIMER_W'(CONVERT_CYCLES - 1);
   localparam logic [TIMER_W-1:0] TIMER_ONE = TIMER_W'(1);
   localparam logic [TIMER_W-1:0] TIMER_NIL = '0;

   // ----------------------------------------------------------------------
   // Serial link, running on the host's serial clock.
   // ----------------------------------------------------------------------
   logic [WORD_W-1:0] rx_word;
   logic              rx_tgl;
   logic [WORD_W-1:0] result_word_ff;
   logic              result_tgl_ff;

   serial_link_port #(
      .WIDTH (WORD_W)
   ) u_link (
      .sclk_i      (sclk_i),
      .reset_i     (reset_i),
      .arm_i       (receive_frame_sync_i),
      .frame_n_i   (transmit_frame_sync_i),
      .din_i       (sdata_i),
      .dout_o      (sdata_o),
      .tx_word_i   (result_word_ff),
      .tx_tgl_i    (result_tgl_ff),
      .rx_word_o   (rx_word),
      .rx_tgl_o    (rx_tgl)
   );

   // ----------------------------------------------------------------------
   // Crossings into the converter clock.
   // ----------------------------------------------------------------------
   logic trig_s1_ff;
   logic trig_s2_ff;
   logic trig_d_ff;
   logic rx_s1_ff;
   logic rx_s2_ff;
   logic rx_d_ff;

   // The trigger pin and the word toggle each pass two flops before use.
   // The trigger flops reset high, to the pin's idle level, so that no
   // false edge is seen as reset lets go.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         trig_s1_ff <= 1'b1;
         trig_s2_ff <= 1'b1;
         trig_d_ff  <= 1'b1;
         rx_s1_ff   <= 1'b0;
         rx_s2_ff   <= 1'b0;
         rx_d_ff    <= 1'b0;
      end else begin
         trig_s1_ff <= conv_trigger_n_i;
         trig_s2_ff <= trig_s1_ff;
         trig_d_ff  <= trig_s2_ff;
         rx_s1_ff   <= rx_tgl;
         rx_s2_ff   <= rx_s1_ff;
         rx_d_ff    <= rx_s2_ff;
      end
   end

   // The received word is stable for many serial edges after its toggle
   // flips, so it is safe to take once the toggle has been synchronised.
   wire trig_fall = trig_d_ff & ~trig_s2_ff;
   wire trig_rise = ~trig_d_ff & trig_s2_ff;
   wire cfg_wr    = rx_s2_ff ^ rx_d_ff;
   wire [1:0] cfg_pd = {rx_word[CTRL_LSB+PD1_BIT], rx_word[CTRL_LSB+PD0_BIT]};
   wire cfg_ext   = rx_word[CTRL_LSB+EXTERNAL_REF_SELECT_BIT];

   // ----------------------------------------------------------------------
   // Power state machine and conversion timing.
   // ----------------------------------------------------------------------
   pwr_state_t        state_ff;
   pwr_state_t        nxt_state;
   logic [1:0]        pd_ff;
   logic [1:0]        nxt_pd;
   logic              ext_ff;
   logic              nxt_ext;
   logic [TIMER_W-1:0] pwr_cnt_ff;
   logic [TIMER_W-1:0] nxt_pwr_cnt;
   logic [TIMER_W-1:0] conv_cnt_ff;
   logic [TIMER_W-1:0] nxt_conv_cnt;
   logic              conv_ff;
   logic              nxt_conv;
   logic              pend_ff;
   logic              nxt_pend;

   wire conv_end  = conv_ff && (conv_cnt_ff == TIMER_NIL);
   wire auto_mode = (pd_ff == PD_PARTIAL) || (pd_ff == PD_AUTO_FULL);
   wire start_now = (state_ff == PWR_ACTIVE) && !conv_ff && (trig_fall || pend_ff);

   // Configuration writes take effect at once; the trigger-driven
   // power-down decision only happens when a conversion ends.
   always_comb begin
      nxt_state    = state_ff;
      nxt_pd       = pd_ff;
      nxt_ext      = ext_ff;
      nxt_pwr_cnt  = (pwr_cnt_ff != TIMER_NIL) ? pwr_cnt_ff - TIMER_ONE : TIMER_NIL;
      nxt_conv_cnt = (conv_cnt_ff != TIMER_NIL) ? conv_cnt_ff - TIMER_ONE : TIMER_NIL;
      nxt_conv     = conv_ff;
      nxt_pend     = pend_ff;
      unique case (state_ff)
         PWR_OFF: begin
            nxt_pend = 1'b0;
         end
         PWR_RISING: begin
            if (trig_fall) begin
               nxt_pend = 1'b1;                                             // R22
            end
            if (pwr_cnt_ff == TIMER_NIL) begin
               nxt_state = PWR_ACTIVE;                                      // R22
            end
         end
         PWR_ACTIVE: begin
            if (start_now) begin
               nxt_conv     = 1'b1;                                         // R21
               nxt_conv_cnt = CONV_LOAD;
               nxt_pend     = 1'b0;
            end
            if (conv_end) begin
               nxt_conv = 1'b0;
               unique case (pd_ff)                                          // R3 R23
                  PD_FULL_UP:   nxt_state = PWR_ACTIVE;
                  PD_FULL_DOWN: nxt_state = PWR_OFF;
                  PD_PARTIAL:   nxt_state = trig_s2_ff ? PWR_ACTIVE : PWR_PARTIAL; // R4
                  PD_AUTO_FULL: nxt_state = trig_s2_ff ? PWR_ACTIVE : PWR_FULL;    // R4
               endcase
            end
         end
         PWR_PARTIAL, PWR_FULL: begin
            if (trig_rise && auto_mode) begin
               nxt_state   = PWR_RISING;                                    // R5
               nxt_pwr_cnt = WAKE_LOAD;                                     // R8
            end
         end
      endcase
      if (cfg_wr) begin
         nxt_pd  = cfg_pd;
         nxt_ext = cfg_ext;                                                 // R1
         if (cfg_pd == PD_FULL_DOWN) begin
            nxt_state = PWR_OFF;                                            // R3
            nxt_conv  = 1'b0;
         end else if (cfg_pd == PD_FULL_UP &&
                      (state_ff == PWR_OFF || state_ff == PWR_PARTIAL ||
                       state_ff == PWR_FULL)) begin
            nxt_state   = PWR_RISING;                                       // R7
            nxt_pwr_cnt = (state_ff == PWR_OFF && !cfg_ext) ? COLD_LOAD : WAKE_LOAD; // R8
         end
      end
   end

   // State and timer registers; reset leaves the core in low current.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_ff    <= PWR_OFF;                                            // R7
         pd_ff       <= PD_FULL_DOWN;
         ext_ff      <= 1'b0;
         pwr_cnt_ff  <= '0;
         conv_cnt_ff <= '0;
         conv_ff     <= 1'b0;
         pend_ff     <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         pd_ff       <= nxt_pd;
         ext_ff      <= nxt_ext;
         pwr_cnt_ff  <= nxt_pwr_cnt;
         conv_cnt_ff <= nxt_conv_cnt;
         conv_ff     <= nxt_conv;
         pend_ff     <= nxt_pend;
      end
   end

   // ----------------------------------------------------------------------
   // Result word toward the serial port.
   // ----------------------------------------------------------------------
   // Code is passed unchanged (straight binary) and left-justified.
   wire [WORD_W-1:0] nxt_result = {adc_code_i, {(WORD_W-CODE_W){1'b0}}}; // R2 R19

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         result_word_ff <= '0;
         result_tgl_ff  <= 1'b0;
      end else if (conv_end && state_ff == PWR_ACTIVE) begin
         result_word_ff <= nxt_result;                                      // R19
         result_tgl_ff  <= ~result_tgl_ff;
      end
   end

   // ----------------------------------------------------------------------
   // Status outputs, all registered.
   // ----------------------------------------------------------------------
   // The amplifier stays on through partial power-down so the reference
   // capacitor need not recharge; an external reference turns it off.
   wire nxt_amp_on = !nxt_ext && (nxt_state == PWR_RISING ||
                                  nxt_state == PWR_ACTIVE ||
                                  nxt_state == PWR_PARTIAL);               // R1 R6
   wire nxt_core_on = (nxt_state == PWR_RISING) || (nxt_state == PWR_ACTIVE);
   wire nxt_ready   = (nxt_state == PWR_ACTIVE) && !nxt_conv;
   wire nxt_done    = conv_end && (state_ff == PWR_ACTIVE);

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         external_ref_select_o <= 1'b0;
         ref_amp_on_o          <= 1'b0;
         core_power_on_o       <= 1'b0;
         hold_o                <= 1'b0;
         conv_done_o           <= 1'b0;
         ready_o               <= 1'b0;
         power_mode_o          <= PD_FULL_DOWN;
      end else begin
         external_ref_select_o <= nxt_ext;                                 // R1
         ref_amp_on_o          <= nxt_amp_on;
         core_power_on_o       <= nxt_core_on;
         hold_o                <= nxt_conv;                                // R21
         conv_done_o           <= nxt_done;
         ready_o               <= nxt_ready;
         power_mode_o          <= nxt_pd;
      end
   end

endmodule

// ### serial_link_port.sv
module serial_link_port #(
   parameter int WIDTH = 16
) (
   input  wire logic             sclk_i,
   input  wire logic             reset_i,
   input  wire logic             arm_i,
   input  wire logic             frame_n_i,
   input  wire logic             din_i,
   output logic                  dout_o,
   input  wire logic [WIDTH-1:0] tx_word_i,
   input  wire logic             tx_tgl_i,
   output logic      [WIDTH-1:0] rx_word_o,
   output logic                  rx_tgl_o
);

   if (WIDTH < 2 || WIDTH > 255) begin : g_bad_width
      $error("Serial word width out of range.");
   end

   localparam logic [7:0] LAST = 8'(WIDTH - 1);
   localparam logic [7:0] FULL = 8'(WIDTH);

   // ----------------------------------------------------------------------
   // Reset and toggle crossings into the serial clock.
   // ----------------------------------------------------------------------
   // The serial clock may stop between frames, so reset here needs a few
   // serial edges while reset is held.
   logic rst_s1_ff;
   logic rst_s2_ff;
   logic tx_s1_ff;
   logic tx_s2_ff;

   always_ff @(posedge sclk_i) begin
      rst_s1_ff <= reset_i;
      rst_s2_ff <= rst_s1_ff;
      tx_s1_ff  <= tx_tgl_i;
      tx_s2_ff  <= tx_s1_ff;
   end

   // ----------------------------------------------------------------------
   // Shifter.
   // ----------------------------------------------------------------------
   logic [7:0]       cnt_ff;
   logic [WIDTH-1:0] tx_sh_ff;
   logic [WIDTH-1:0] rx_sh_ff;
   logic [WIDTH-1:0] held_ff;
   logic             ack_ff;

   wire              fresh    = tx_s2_ff ^ ack_ff;
   wire [WIDTH-1:0]  load     = fresh ? tx_word_i : held_ff;
   wire              shifting = !arm_i && !frame_n_i && (cnt_ff != FULL);
   wire [WIDTH-1:0]  nxt_rx   = {rx_sh_ff[WIDTH-2:0], din_i};

   // An edge with the arm line high restarts the count and loads the
   // newest result; a read in progress is never overwritten mid-word.
   always_ff @(posedge sclk_i) begin
      if (rst_s2_ff) begin
         cnt_ff    <= FULL;
         tx_sh_ff  <= '0;
         rx_sh_ff  <= '0;
         held_ff   <= '0;
         ack_ff    <= 1'b0;
         rx_word_o <= '0;
         rx_tgl_o  <= 1'b0;
      end else if (arm_i) begin
         cnt_ff   <= '0;
         tx_sh_ff <= load;
         held_ff  <= load;
         ack_ff   <= tx_s2_ff;
      end else if (shifting) begin
         cnt_ff   <= cnt_ff + 8'h01;
         tx_sh_ff <= {tx_sh_ff[WIDTH-2:0], 1'b0};                           // R13
         rx_sh_ff <= nxt_rx;                                                // R13
         if (cnt_ff == LAST) begin
            rx_word_o <= nxt_rx;
            rx_tgl_o  <= ~rx_tgl_o;
         end
      end
   end

   // Most significant bit leaves first.
   assign dout_o = tx_sh_ff[WIDTH-1];                                       // R19

endmodule

// ### adc_power_checker_properties.sv
module adc_power_checker
   import adc_pwr_pkg::*;
#(
   parameter int COLD_START_CYCLES = 24,
   parameter int WAKE_CYCLES       = 16,
   parameter int CONVERT_CYCLES    = 40
) (
   input wire logic              ref_clk_i,
   input wire logic              reset_i,
   input wire logic              sclk_i,
   input wire logic              receive_frame_sync_i,
   input wire logic              transmit_frame_sync_i,
   input wire logic              sdata_i,
   input wire logic              sdata_o,
   input wire logic              conv_trigger_n_i,
   input wire logic [CODE_W-1:0] adc_code_i,
   input wire logic              external_ref_select_o,
   input wire logic              ref_amp_on_o,
   input wire logic              core_power_on_o,
   input wire logic              hold_o,
   input wire logic              conv_done_o,
   input wire logic              ready_o,
   input wire logic [1:0]        power_mode_o
);
   // Worst wait from power rising to ready or hold, a cold start plus a remembered conversion.
   localparam int UP_LIM = COLD_START_CYCLES + CONVERT_CYCLES + 16;

   logic [15:0] run_ff;
   logic [15:0] nxt_run;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   // Length of the current hold run, so the conversion time can be checked to a window of two cycles under and one over.
   assign nxt_run = hold_o ? run_ff + 16'h0001 : 16'h0000;
   always_ff @(posedge ref_clk_i) begin
      run_ff <= reset_i ? 16'h0000 : nxt_run;
   end

   // -----------------------------------------------------------------
   // Power and conversion relations.
   // -----------------------------------------------------------------
   ext_ref_amp_a: assert property (external_ref_select_o |-> !ref_amp_on_o)
      else $error("reference amplifier powered with external reference");
   hold_len_a: assert property (conv_done_o |-> run_ff >= CONVERT_CYCLES - 2 &&
      run_ff <= CONVERT_CYCLES + 1) else $error("conversion length wrong");
   done_pulse_a: assert property (conv_done_o |=> !conv_done_o)
      else $error("conversion end longer than one cycle");
   ready_power_a: assert property (ready_o |-> core_power_on_o && !hold_o)
      else $error("ready without power or while converting");
   hold_power_a: assert property (hold_o |-> core_power_on_o)
      else $error("converting while unpowered");
   mode_off_a: assert property (power_mode_o == PD_FULL_DOWN [*4] |->
      !core_power_on_o && !ref_amp_on_o) else $error("full power-down not honoured");
   partial_ref_a: assert property ($fell(core_power_on_o) && power_mode_o == PD_PARTIAL &&
      !external_ref_select_o |-> ref_amp_on_o) else $error("reference lost in partial down");
   up_stay_a: assert property (power_mode_o == PD_FULL_UP && conv_done_o |=>
      core_power_on_o [*2]) else $error("powered down in full power-up mode");
   wake_time_a: assert property ($rose(core_power_on_o) |-> ##[1:UP_LIM]
      (ready_o || hold_o)) else $error("power-up took too long");

   cover property ($rose(hold_o));
   cover property ($fell(core_power_on_o) && power_mode_o == PD_PARTIAL);
   cover property (conv_done_o && power_mode_o == PD_AUTO_FULL);
endmodule

bind adc_power_reference_control adc_power_checker #(
   .COLD_START_CYCLES(COLD_START_CYCLES),
   .WAKE_CYCLES(WAKE_CYCLES),
   .CONVERT_CYCLES(CONVERT_CYCLES)
) checker_i (
   .ref_clk_i(ref_clk_i), .reset_i(reset_i), .sclk_i(sclk_i),
   .receive_frame_sync_i(receive_frame_sync_i), .transmit_frame_sync_i(transmit_frame_sync_i),
   .sdata_i(sdata_i), .sdata_o(sdata_o), .conv_trigger_n_i(conv_trigger_n_i),
   .adc_code_i(adc_code_i), .external_ref_select_o(external_ref_select_o),
   .ref_amp_on_o(ref_amp_on_o), .core_power_on_o(core_power_on_o), .hold_o(hold_o),
   .conv_done_o(conv_done_o), .ready_o(ready_o), .power_mode_o(power_mode_o)
);

// ### host_link_model.sv
module host_link_model (
   input  wire logic data_in_i,
   output logic      sclk_o,
   output logic      receive_frame_sync_o,
   output logic      transmit_frame_sync_o,
   output logic      data_out_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // The serial clock stands still low between frames; sync lines idle inactive.
   initial begin
      sclk_o = 1'b0;
      receive_frame_sync_o = 1'b0;
      transmit_frame_sync_o = 1'b1;
      data_out_o = 1'b0;
   end

   // Bare clock edges, used while the link side comes out of reset.
   task automatic tick(input int n);
      repeat (n) begin
         #62.5 sclk_o = 1'b1;
         #62.5 sclk_o = 1'b0;
      end
   endtask

   // One full-duplex word: three arm edges, then sixteen shift edges, MSB first.
   task automatic xfer(input logic [15:0] wr, output logic [15:0] rd);
      int i;
      // The arm line stays up for three edges: the newest result's toggle
      // needs two serial edges to cross before the third one loads it.
      #3.7 receive_frame_sync_o = 1'b1;
      tick(3);
      receive_frame_sync_o = 1'b0;
      transmit_frame_sync_o = 1'b0;
      for (i = 15; i >= 0; i--) begin
         data_out_o = wr[i];
         #62.5 rd[i] = data_in_i;
         sclk_o = 1'b1;
         #62.5 sclk_o = 1'b0;
      end
      transmit_frame_sync_o = 1'b1;
      // A released line must not keep looking like valid data.
      data_out_o = ~wr[0];
   endtask
endmodule

// ### adc_power_reference_control_bench.sv
`define CHECK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
   $display("FAIL %s expected %h seen %h", what, exp, got); end end

module adc_power_reference_control_bench
   import adc_pwr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // Short counts keep the run brief; every timing expectation derives from these.
   localparam int WAKE = 16;
   localparam int CONV = 40;
   localparam int COLD = 24;

   logic ref_clk, rst, sclk, receive_frame_sync, transmit_frame_sync, din, dout, trig_n;
   logic ext, amp, core, hold, done, ready;
   logic [1:0]        mode;
   logic [CODE_W-1:0] code;
   int bad_count = 0;
   int tests_run = 0;

   adc_power_reference_control #(
      .COLD_START_CYCLES(COLD), .WAKE_CYCLES(WAKE), .CONVERT_CYCLES(CONV)
   ) dut (
      .ref_clk_i(ref_clk), .reset_i(rst), .sclk_i(sclk), .receive_frame_sync_i(receive_frame_sync),
      .transmit_frame_sync_i(transmit_frame_sync), .sdata_i(din), .sdata_o(dout), .conv_trigger_n_i(trig_n),
      .adc_code_i(code), .external_ref_select_o(ext), .ref_amp_on_o(amp),
      .core_power_on_o(core), .hold_o(hold), .conv_done_o(done), .ready_o(ready),
      .power_mode_o(mode)
   );

   host_link_model host (
      .data_in_i(dout), .sclk_o(sclk), .receive_frame_sync_o(receive_frame_sync),
      .transmit_frame_sync_o(transmit_frame_sync), .data_out_o(din)
   );

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // -----------------------------------------------------------------
   // Helpers.
   // -----------------------------------------------------------------
   task automatic conclude();
      if (bad_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Inputs move 1 ns after the edge so no race with the design's sampling.
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // High pulse of pre cycles, fall starts a conversion; level at the end picks the mode.
   task automatic convert(input logic [9:0] c, input int pre, input logic low_end,
                          output int wait_n);
      int n;
      code = c;
      trig_n = 1'b1;
      cyc(pre);
      trig_n = 1'b0;
      wait_n = 0;
      while (hold !== 1'b1 && wait_n < 400) begin
         cyc(1);
         wait_n++;
      end
      if (!low_end) trig_n = 1'b1;
      n = 0;
      while (done !== 1'b1 && n < 400) begin
         cyc(1);
         n++;
      end
      `CHECK("conversion time", 1'b1, n >= CONV - 1 && n <= CONV + 1)
      cyc(3);
   endtask

   // Long enough for every frame and conversion below, with room to spare.
   initial begin
      #200000;
      bad_count++;
      conclude();
   end

   // -----------------------------------------------------------------
   // Test sequence.
   // -----------------------------------------------------------------
   initial begin
      logic [15:0] rd;
      int w;
      rst = 1'b1;
      trig_n = 1'b1;
      code = 10'h000;
      host.tick(3);
      cyc(5);
      rst = 1'b0;
      host.tick(2);
      `CHECK("state after reset", 6'h00, {mode, core, amp, hold, ready})
      trig_n = 1'b0;
      cyc(12);
      `CHECK("trigger while off", 1'b0, hold)
      trig_n = 1'b1;
      host.xfer(16'h6040, rd);
      w = 0;
      while (ready !== 1'b1 && w < 200) begin
         cyc(1);
         w++;
      end
      `CHECK("wake with external ref", 1'b1, w <= WAKE + 8)
      `CHECK("mode after first write", 2'h3, mode)
      `CHECK("reference select", 2'b10, {ext, amp})
      cyc(100);
      convert(10'h2A5, 2, 1'b1, w);
      `CHECK("full power-up ignores trigger", 2'b11, {core, ready})
      host.xfer(16'h4040, rd);
      `CHECK("result word", {10'h2A5, 6'h00}, rd)
      convert(10'h3FF, 2, 1'b0, w);
      `CHECK("trigger high stays up", 1'b1, core)
      convert(10'h001, 2, 1'b1, w);
      `CHECK("trigger low powers down", 2'b00, {core, ready})
      cyc(400);
      convert(10'h0C3, 3, 1'b1, w);
      `CHECK("fall during power-up waits", 1'b1, w >= WAKE - 4)
      host.xfer(16'h2000, rd);
      `CHECK("result after wake", {10'h0C3, 6'h00}, rd)
      convert(10'h155, 3, 1'b1, w);
      `CHECK("partial power-down", 3'b010, {core, amp, ext})
      host.xfer(16'h0000, rd);
      cyc(8);
      `CHECK("full power-down", 4'h0, {mode, core, amp})
      `CHECK("result in partial down", {10'h155, 6'h00}, rd)
      host.xfer(16'h6000, rd);
      w = 0;
      while (ready !== 1'b1 && w < 200) begin
         cyc(1);
         w++;
      end
      `CHECK("cold start wait", 1'b1, w >= COLD - 8 && w <= COLD + 4)
      `CHECK("internal reference", 2'b01, {ext, amp})
      conclude();
   end
endmodule
